/* File: core/ssp_defs.svh */
// constants of the serial programming register bank
// Function
// (R1) 16-clock strobe is a normal register write
// (R2) hand sample over on divided vco falling edge
// (R3) 2 to 12 clock strobe loads modulation sample
// (R4) short samples come from data pin by default
// (R5) modulation config may select alternate modulation pin
// (R6) resynchronize every serial input to reference clock
// (R7) shift sample left by magnitude offset
// (R8) controller keeps sample plus dividend within 0.5625
// (R9) address first, then data, msb first
// (R10) no read path; all registers write only
// (R11) reset clears all, dividers 0x0/0x3 to 0x006
// (R12) controller keeps main index within legal range
// (R13) main dividend is 10 upper plus 8 lower
// (R14) main dividend is two's complement
// (R15) 10-bit mode uses upper dividend only
// (R16) dividend is offset added to integer ratio
// (R17) controller keeps second index within legal range
// (R18) second dividend is one 10-bit value
// (R19) strobe ending before edge 13 is modulation; code ignores a 1-clock strobe, only 2 to 12 load a sample
// (R20) fractional ratio applies on upper dividend write
// (R21) integer ratio applies on divider write
// (R22) other strobe lengths are ignored
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

`define SSP_NREGS 10
`define SSP_ADDR_MAIN_DIV 4'h0
`define SSP_ADDR_MAIN_UP 4'h1
`define SSP_ADDR_MAIN_LO 4'h2
`define SSP_ADDR_SEC_DIV 4'h3
`define SSP_ADDR_SEC_FRAC 4'h4
`define SSP_ADDR_REF_PRE 4'h5
`define SSP_ADDR_DET_GAIN 4'h6
`define SSP_ADDR_PWR_OUT 4'h7
`define SSP_ADDR_MOD_CFG 4'h8
`define SSP_ADDR_MOD_SMP 4'h9
`define SSP_ADDR_LAST 4'h9
`define SSP_DIV_RESET 12'h006
`define SSP_REG_RESET 12'h000
`define SSP_FRAME_LEN 5'h10
`define SSP_SHORT_MIN 5'h02
`define SSP_SHORT_MAX 5'h0C
`define SSP_CNT_SAT 5'h11
`define SSP_SMP_LEN 5'h0C
`define SSP_MAIN_INT_BIT 2
`define SSP_SEC_INT_BIT 3
`define SSP_MAIN_10B_BIT 4
`define SSP_MOD_SRC_BIT 0
`define SSP_MOD_OFS_LSB 1
`define SSP_MOD_OFS_MSB 3
`define SSP_LO_PAD 8'h00

`endif

/* File: core/ssp_pkg.sv */
// types of the serial programming register bank
`default_nettype none
package ssp_pkg;
   typedef struct packed {
      logic [8:0] int_idx;
      logic signed [17:0] frac;
   } ssp_main_ratio_t;
   typedef struct packed {
      logic [8:0] int_idx;
      logic signed [9:0] frac;
   } ssp_sec_ratio_t;
   typedef struct packed {
      logic vco;
      logic mod;
      logic data;
      logic sclk;
      logic sel_n;
   } ssp_pins_t;
   typedef enum logic [1:0] {
      SSP_IDLE = 2'b00,
      SSP_SHIFT = 2'b01,
      SSP_DONE = 2'b11
   } ssp_state_t;
endpackage
`default_nettype wire

/* File: core/ssp_buf2.sv */
// two-entry buffer with valid and ready on both sides
`default_nettype none
module ssp_buf2 #(
   parameter int W = 12,
   parameter int DEPTH = 2
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] fill;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   assign in_ready_o = (fill != (AW+1)'(DEPTH));
   assign out_valid_o = (fill != '0);
   assign out_data_o = mem[rd_ptr];

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= bump(wr_ptr);
         if (pop)
            rd_ptr <= bump(rd_ptr);
         fill <= (AW+1)'(fill + (AW+1)'(push) - (AW+1)'(pop));
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (push)
         mem[wr_ptr] <= in_data_i;
   end
endmodule
`default_nettype wire

/* File: core/ssp_regs.sv */
// serial programming port and write-only register bank
`default_nettype none
`include "ssp_defs.svh"
module ssp_regs
   import ssp_pkg::*;
#(
   parameter int SMP_W = 12,
   parameter int MOD_W = 20
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic sel_n_i,
   input wire logic ser_clk_i,
   input wire logic ser_data_i,
   input wire logic mod_in_i,
   input wire logic divided_main_vco_clock_i,
   output ssp_main_ratio_t main_ratio_o,
   output ssp_sec_ratio_t sec_ratio_o,
   output logic [11:0] ref_prescalers_o,
   output logic [11:0] detector_gain_o,
   output logic [11:0] powerdown_outsel_o,
   output logic signed [MOD_W-1:0] mod_word_o,
   output logic mod_stb_o
);
   localparam int HOLD_MAX = 8;

   // input synchronisers
   ssp_pins_t pins_raw;
   ssp_pins_t sync1;
   ssp_pins_t sync2;
   ssp_pins_t sync3;
   assign pins_raw = '{vco: divided_main_vco_clock_i, mod: mod_in_i, data: ser_data_i,
                       sclk: ser_clk_i, sel_n: sel_n_i};

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         sync1 <= '{vco: 1'b0, mod: 1'b0, data: 1'b0, sclk: 1'b0, sel_n: 1'b1};
         sync2 <= '{vco: 1'b0, mod: 1'b0, data: 1'b0, sclk: 1'b0, sel_n: 1'b1};
         sync3 <= '{vco: 1'b0, mod: 1'b0, data: 1'b0, sclk: 1'b0, sel_n: 1'b1};
      end
      else
      begin
         sync1 <= pins_raw; // see (R6)
         sync2 <= sync1; // see (R6)
         sync3 <= sync2;
      end
   end

   wire sclk_rise = sync2.sclk && !sync3.sclk;
   wire sel_active = !sync2.sel_n;
   wire vco_fall = !sync2.vco && sync3.vco;

   // frame state
   ssp_state_t state;
   ssp_state_t next_state;
   logic [4:0] bit_cnt;
   logic [15:0] sh_data;
   logic [SMP_W-1:0] sh_mod;
   logic [9:0][11:0] regs;

   always_comb
   begin
      next_state = state;
      case (state)
         SSP_IDLE:
            if (sel_active)
               next_state = SSP_SHIFT;
         SSP_SHIFT:
            if (!sel_active)
               next_state = SSP_DONE;
         SSP_DONE:
            next_state = SSP_IDLE;
         default:
            next_state = SSP_IDLE;
      endcase
   end

   wire shift_en = (state == SSP_SHIFT) && sel_active && sclk_rise;
   wire done = (state == SSP_DONE);

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         state <= SSP_IDLE;
         bit_cnt <= '0;
         sh_data <= '0;
         sh_mod <= '0;
      end
      else
      begin
         state <= next_state;
         if (state == SSP_IDLE)
            bit_cnt <= '0;
         else if (shift_en && bit_cnt != `SSP_CNT_SAT)
            bit_cnt <= 5'(bit_cnt + 1'b1);
         if (shift_en)
         begin
            sh_data <= {sh_data[14:0], sync2.data}; // see (R9)
            sh_mod <= {sh_mod[SMP_W-2:0], sync2.mod};
         end
      end
   end

   // frame decode
   function automatic logic [11:0] sext(input logic [11:0] v, input logic [4:0] n);
      logic [3:0] pad;
      pad = 4'(`SSP_SMP_LEN - n);
      sext = 12'($signed(12'(v << pad)) >>> pad);
   endfunction

   wire len_frame = (bit_cnt == `SSP_FRAME_LEN); // see (R1)
   wire len_short = (bit_cnt >= `SSP_SHORT_MIN) && (bit_cnt <= `SSP_SHORT_MAX); // see (R3) (R19)
   wire [3:0] frame_addr = sh_data[15:12]; // see (R9)
   wire [11:0] frame_data = sh_data[11:0];
   wire mod_from_pin = regs[`SSP_ADDR_MOD_CFG][`SSP_MOD_SRC_BIT]; // see (R5)
   wire [11:0] short_raw = mod_from_pin ? 12'(sh_mod) : sh_data[11:0]; // see (R4) (R5)
   wire [11:0] short_smp = sext(short_raw, bit_cnt);
   wire frame_wr = done && len_frame && (frame_addr <= `SSP_ADDR_LAST);
   wire short_wr = done && len_short; // see (R3)

   function automatic logic wr_at(input logic [3:0] a, input logic we, input logic [3:0] adr);
      wr_at = we && (adr == a);
   endfunction

   function automatic logic [11:0] reset_val(input int i);
      reset_val = (i == int'(`SSP_ADDR_MAIN_DIV) || i == int'(`SSP_ADDR_SEC_DIV)) ?
                  `SSP_DIV_RESET : `SSP_REG_RESET;
   endfunction

   // register bank; nothing here is ever read back out
   genvar gi;
   generate
      for (gi = 0; gi < `SSP_NREGS; gi++)
      begin : g_reg
         wire sel_here = wr_at(4'(gi), frame_wr, frame_addr);
         wire smp_here = (gi == int'(`SSP_ADDR_MOD_SMP)) && short_wr;
         always_ff @(posedge clk_i)
         begin
            if (sys_rst_i)
               regs[gi] <= reset_val(gi); // see (R11)
            else if (smp_here)
               regs[gi] <= short_smp; // see (R3)
            else if (sel_here)
               regs[gi] <= frame_data; // see (R1) (R10)
         end
      end
   endgenerate

   // ratio application
   wire [11:0] pwr = regs[`SSP_ADDR_PWR_OUT];
   wire main_int = pwr[`SSP_MAIN_INT_BIT];
   wire sec_int = pwr[`SSP_SEC_INT_BIT];
   wire main_10b = pwr[`SSP_MAIN_10B_BIT];
   wire wr_main_div = wr_at(`SSP_ADDR_MAIN_DIV, frame_wr, frame_addr);
   wire wr_main_up = wr_at(`SSP_ADDR_MAIN_UP, frame_wr, frame_addr);
   wire wr_sec_div = wr_at(`SSP_ADDR_SEC_DIV, frame_wr, frame_addr);
   wire wr_sec_frac = wr_at(`SSP_ADDR_SEC_FRAC, frame_wr, frame_addr);
   wire [7:0] main_lo = main_10b ? `SSP_LO_PAD : regs[`SSP_ADDR_MAIN_LO][7:0]; // see (R15)
   wire [17:0] main_frac_new = {frame_data[9:0], main_lo}; // see (R13) (R14)
   wire main_apply_int = main_int && wr_main_div; // see (R21)
   wire main_apply_frac = !main_int && wr_main_up; // see (R20)
   wire sec_apply_int = sec_int && wr_sec_div; // see (R21)
   wire sec_apply_frac = !sec_int && wr_sec_frac; // see (R20)

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         main_ratio_o <= '{int_idx: 9'(`SSP_DIV_RESET), frac: '0};
         sec_ratio_o <= '{int_idx: 9'(`SSP_DIV_RESET), frac: '0};
      end
      else
      begin
         if (main_apply_int)
            main_ratio_o.int_idx <= frame_data[8:0]; // see (R21)
         else if (main_apply_frac)
            main_ratio_o <= '{int_idx: regs[`SSP_ADDR_MAIN_DIV][8:0],
                              frac: $signed(main_frac_new)}; // see (R16) (R20)
         if (sec_apply_int)
            sec_ratio_o.int_idx <= frame_data[8:0]; // see (R21)
         else if (sec_apply_frac)
            sec_ratio_o <= '{int_idx: regs[`SSP_ADDR_SEC_DIV][8:0],
                             frac: $signed(frame_data[9:0])}; // see (R18) (R16)
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         ref_prescalers_o <= `SSP_REG_RESET;
         detector_gain_o <= `SSP_REG_RESET;
         powerdown_outsel_o <= `SSP_REG_RESET;
      end
      else
      begin
         ref_prescalers_o <= regs[`SSP_ADDR_REF_PRE];
         detector_gain_o <= regs[`SSP_ADDR_DET_GAIN];
         powerdown_outsel_o <= pwr;
      end
   end

   // sample handover toward the modulation unit
   logic fresh;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [11:0] buf_out;
   wire smp_written = short_wr || wr_at(`SSP_ADDR_MOD_SMP, frame_wr, frame_addr);

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         fresh <= 1'b0;
      else if (smp_written)
         fresh <= 1'b1; // see (R2)
      else if (buf_in_ready)
         fresh <= 1'b0;
   end

   ssp_buf2 #(.W(12), .DEPTH(2)) u_buf (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(fresh),
      .in_ready_o(buf_in_ready),
      .in_data_i(regs[`SSP_ADDR_MOD_SMP]),
      .out_valid_o(buf_out_valid),
      .out_ready_i(vco_fall),
      .out_data_o(buf_out)
   );

   wire [2:0] mag_ofs = regs[`SSP_ADDR_MOD_CFG][`SSP_MOD_OFS_MSB:`SSP_MOD_OFS_LSB];
   wire signed [MOD_W-1:0] scaled = MOD_W'($signed(buf_out)) <<< mag_ofs; // see (R7)
   wire handover = buf_out_valid && vco_fall; // see (R2)

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         mod_word_o <= '0;
         mod_stb_o <= 1'b0;
      end
      else
      begin
         mod_stb_o <= handover;
         if (handover)
            mod_word_o <= scaled; // see (R2) (R7)
      end
   end

   // checks: frame decode
   a_ignore_bad_len: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R22)
      done && !len_frame && !len_short
      |=> $stable(regs))
      else $error("bad strobe length changed a register");
   a_bad_addr: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R22)
      done && len_frame && frame_addr > `SSP_ADDR_LAST
      |=> $stable(regs))
      else $error("frame to unused address changed a register");
   a_idle_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R22)
      done
      |=> state == SSP_IDLE [*1] ##[1:HOLD_MAX] 1'b1)
      else $error("decode state did not return to idle");
   a_frame_write: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R1)
      done && len_frame && frame_addr == `SSP_ADDR_DET_GAIN
      |=> regs[`SSP_ADDR_DET_GAIN] == $past(sh_data[11:0]))
      else $error("16-bit frame not written to addressed register");
   a_gain_copy: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R1)
      !$past(sys_rst_i)
      |-> detector_gain_o == $past(regs[`SSP_ADDR_DET_GAIN]))
      else $error("gain output does not follow its register");
   a_reset_ratio: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R11)
      $fell(sys_rst_i) |-> main_ratio_o.int_idx == 9'(`SSP_DIV_RESET)
      && sec_ratio_o.int_idx == 9'(`SSP_DIV_RESET))
      else $error("divider ratios not at reset value");
   a_sync_depth: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R6)
      shift_en
      |-> $past(ser_clk_i, 2) && !$past(ser_clk_i, 3))
      else $error("serial clock used before two stages");

   // checks: modulation samples
   a_short_sample: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R3)
      short_wr
      |=> regs[`SSP_ADDR_MOD_SMP] == $past(short_smp))
      else $error("short strobe sample not loaded");
   a_short_source: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R4)
      short_wr && !mod_from_pin && bit_cnt == `SSP_SMP_LEN
      |=> regs[`SSP_ADDR_MOD_SMP] == $past(sh_data[11:0]))
      else $error("default short source is not the data pin");
   a_alt_source: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R5)
      short_wr && mod_from_pin
      |=> regs[`SSP_ADDR_MOD_SMP][1:0] == $past(sh_mod[1:0]))
      else $error("alternate short source is not the modulation pin");
   a_handover_edge: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R2)
      mod_stb_o
      |-> $past(vco_fall) && $past(buf_out_valid))
      else $error("sample handed over away from vco falling edge");
   a_stb_single: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R2)
      mod_stb_o
      |=> !mod_stb_o)
      else $error("handover strobe longer than one cycle");
   a_sample_kept: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R2)
      fresh && !buf_in_ready
      |=> fresh [*2] or (fresh ##1 !fresh))
      else $error("pending sample lost under stall");
   a_scale_shift: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R7)
      handover
      |=> mod_word_o == (MOD_W'($signed($past(buf_out))) <<< $past(mag_ofs)))
      else $error("sample not scaled by magnitude offset");

   // checks: ratio application
   a_frac_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R20)
      !main_int && wr_main_div
      |=> $stable(main_ratio_o))
      else $error("fractional ratio changed before upper dividend write");
   a_int_apply: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R21)
      main_apply_int
      |=> main_ratio_o.int_idx == $past(frame_data[8:0]))
      else $error("integer ratio not applied on divider write");
   a_int_keeps_frac: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R21)
      main_apply_int
      |=> $stable(main_ratio_o.frac))
      else $error("integer divider write disturbed the dividend");
   a_sec_int: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R21)
      sec_apply_int
      |=> sec_ratio_o.int_idx == $past(frame_data[8:0]))
      else $error("second integer ratio not applied on divider write");
   a_upper_apply: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R13)
      main_apply_frac
      |=> main_ratio_o.frac == $signed($past(main_frac_new)))
      else $error("dividend not formed from upper and lower parts");
   a_ten_bit: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R15)
      main_apply_frac && main_10b
      |=> main_ratio_o.frac[7:0] == `SSP_LO_PAD)
      else $error("lower dividend used in 10-bit mode");
   a_sec_apply: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (R18)
      sec_apply_frac
      |=> sec_ratio_o.frac == $signed($past(frame_data[9:0])))
      else $error("second dividend not taken as one 10-bit value");

   c_frame: cover property (@(posedge clk_i) disable iff (sys_rst_i) frame_wr);
   c_short: cover property (@(posedge clk_i) disable iff (sys_rst_i) short_wr && mod_from_pin);
   c_handover: cover property (@(posedge clk_i) disable iff (sys_rst_i) mod_stb_o);
   c_stall: cover property (@(posedge clk_i) disable iff (sys_rst_i) fresh && !buf_in_ready);
   c_refused: cover property (@(posedge clk_i) disable iff (sys_rst_i) done && !len_frame && !len_short);
endmodule
`default_nettype wire

/* File: dv/ssp_host_model.sv */
// serial host model: controller or signal processor shifting frames
`default_nettype none
module ssp_host_model (
   input wire logic clk_i,
   output logic sel_n_o,
   output logic ser_clk_o,
   output logic ser_data_o,
   output logic mod_in_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      sel_n_o = 1'b1;
      ser_clk_o = 1'b0;
      ser_data_o = 1'b0;
      mod_in_o = 1'b0;
   end
   // n bits msb first, each bit stable over its clock rise
   task automatic frame(input int n, input logic [16:0] bits, input bit alt);
      int i;
      @(posedge clk_i);
      #1;
      sel_n_o = 1'b0;
      for (i = n - 1; i >= 0; i--)
      begin
         if (alt)
            mod_in_o = bits[i];
         else
            ser_data_o = bits[i];
         repeat (4) @(posedge clk_i);
         #1;
         ser_clk_o = 1'b1;
         repeat (4) @(posedge clk_i);
         #1;
         ser_clk_o = 1'b0;
      end
      repeat (4) @(posedge clk_i);
      #1;
      sel_n_o = 1'b1;
      // released lines do not keep the last bit
      ser_data_o = ~ser_data_o;
      mod_in_o = ~mod_in_o;
      repeat (6) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench of the serial programming register bank
`default_nettype none
module tb_top
   import ssp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, sys_rst_i, sel_n_i, ser_clk_i, ser_data_i, mod_in_i;
   logic divided_main_vco_clock_i, mod_stb_o;
   ssp_main_ratio_t main_ratio_o;
   ssp_sec_ratio_t sec_ratio_o;
   logic [11:0] ref_prescalers_o, detector_gain_o, powerdown_outsel_o;
   logic signed [19:0] mod_word_o;
   int n_fail = 0;
   int check_count = 0;
   int stb_cnt = 0;
   int cyc = 0;
   int last_stb = 0;
   ssp_host_model host_u (.clk_i, .sel_n_o(sel_n_i), .ser_clk_o(ser_clk_i),
      .ser_data_o(ser_data_i), .mod_in_o(mod_in_i));
   ssp_regs #(.SMP_W(12), .MOD_W(20)) dut_u (.clk_i, .sys_rst_i, .sel_n_i, .ser_clk_i,
      .ser_data_i, .mod_in_i, .divided_main_vco_clock_i, .main_ratio_o, .sec_ratio_o,
      .ref_prescalers_o, .detector_gain_o, .powerdown_outsel_o, .mod_word_o, .mod_stb_o);
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cyc++;
      if (mod_stb_o === 1'b1)
         stb_cnt++;
      if (cyc == 20000)
      begin
         n_fail++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [11:0] d);
      host_u.frame(16, {1'b0, a, d}, 1'b0);
      repeat (6) @(posedge clk_i);
   endtask
   function automatic logic [19:0] sext(input int n, input logic [11:0] v);
      logic [19:0] r;
      r = {8'h00, v};
      if (v[n-1])
         r = r | (20'hFFFFF << n);
      return r;
   endfunction
   // one falling edge of the divided vco clock, expect pulses handovers
   task automatic vco_take(input logic [19:0] exp, input int pulses);
      chk(stb_cnt - last_stb, 0);
      #1;
      divided_main_vco_clock_i = 1'b0;
      repeat (8) @(posedge clk_i);
      #1;
      divided_main_vco_clock_i = 1'b1;
      repeat (4) @(posedge clk_i);
      chk(stb_cnt - last_stb, pulses);
      if (pulses > 0)
         chk({12'h000, mod_word_o}, {12'h000, exp});
      last_stb = stb_cnt;
   endtask
   task automatic t_reset();
      chk(main_ratio_o, {9'd6, 18'h0});
      chk(sec_ratio_o, {9'd6, 10'h0});
      chk({ref_prescalers_o, detector_gain_o}, 0);
      chk(powerdown_outsel_o, 0);
      chk({mod_stb_o, mod_word_o}, 0);
      $display("test reset done");
   endtask
   task automatic t_copies();
      wr(4'h5, 12'hABC);
      wr(4'h6, 12'h5A5);
      wr(4'h7, 12'h1E3);
      chk({ref_prescalers_o, detector_gain_o}, 24'hABC5A5);
      chk(powerdown_outsel_o, 12'h1E3);
      $display("test copies done");
   endtask
   task automatic t_main_frac();
      wr(4'h0, 12'h00D);
      chk(main_ratio_o, {9'd6, 18'h0});
      wr(4'h2, 12'h098);
      chk(main_ratio_o, {9'd6, 18'h0});
      wr(4'h1, 12'h07D);
      chk(main_ratio_o, {9'd13, 18'h07D98});
      wr(4'h2, 12'h000);
      wr(4'h1, 12'h3FF);
      chk(main_ratio_o, {9'd13, 18'h3FF00});
      wr(4'h7, 12'h010);
      wr(4'h0, 12'h010);
      wr(4'h2, 12'h0AA);
      wr(4'h1, 12'h334);
      chk(main_ratio_o, {9'd16, 18'h33400});
      $display("test main ratio done");
   endtask
   task automatic t_int_sec();
      wr(4'h7, 12'h00C);
      wr(4'h0, 12'h012);
      chk(main_ratio_o, {9'd18, 18'h33400});
      wr(4'h3, 12'h012);
      chk(sec_ratio_o, {9'd18, 10'h0});
      wr(4'h7, 12'h000);
      wr(4'h3, 12'h1F9);
      chk(sec_ratio_o, {9'd18, 10'h0});
      wr(4'h4, 12'h200);
      chk(sec_ratio_o, {9'd505, 10'h200});
      $display("test integer and second done");
   endtask
   task automatic t_refuse();
      int lens[4] = '{1, 13, 15, 17};
      foreach (lens[i])
         host_u.frame(lens[i], 17'h16FFF, 1'b0);
      wr(4'hA, 12'hFFF);
      chk(detector_gain_o, 12'h5A5);
      chk(sec_ratio_o, {9'd505, 10'h200});
      vco_take(20'h0, 0);
      $display("test refused strobes done");
   endtask
   task automatic t_mod();
      int lens[3] = '{2, 5, 12};
      logic [11:0] vals[3] = '{12'h002, 12'h00B, 12'h7FF};
      wr(4'h8, 12'h000);
      foreach (lens[i])
      begin
         host_u.frame(lens[i], {5'h00, vals[i]}, 1'b0);
         vco_take(sext(lens[i], vals[i]), 1);
      end
      wr(4'h8, 12'h006);
      host_u.frame(5, 17'h00013, 1'b0);
      vco_take(sext(5, 12'h013) << 3, 1);
      wr(4'h8, 12'h007);
      host_u.frame(4, 17'h00005, 1'b1);
      host_u.frame(3, 17'h00004, 1'b1);
      vco_take(sext(4, 12'h005) << 3, 1);
      vco_take(sext(3, 12'h004) << 3, 1);
      wr(4'h9, 12'h801);
      vco_take(sext(12, 12'h801) << 3, 1);
      $display("test modulation done");
   endtask
   initial
   begin
      sys_rst_i = 1'b1;
      divided_main_vco_clock_i = 1'b1;
      repeat (20) @(posedge clk_i);
      #1;
      sys_rst_i = 1'b0;
      @(posedge clk_i);
      t_reset();
      t_copies();
      t_main_frac();
      t_int_sec();
      t_refuse();
      t_mod();
      conclude();
   end
endmodule
`default_nettype wire
